/* latch_low_flag.v */
`timescale 1ns/1ps
`default_nettype none
module latch_low_flag (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Status
    input wire live,
    input wire release_read,
    output reg latched
);
    // Drop wins over the read release so a fall is never missed
    // Drop and hold
    always @(posedge clk) begin
        if (!resetn) begin
            latched <= 1'b0;
        end else if (!live) begin
            latched <= 1'b0;
        end else if (release_read) begin
            latched <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* mgmt_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
    // Clock
    input wire logic clk,
    // Register access
    output logic reg_write,
    output logic reg_read,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    initial begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // Released lines are inverted so stale values never pass
    task wr(input logic [15:0] ad, input logic [15:0] d);
        @(negedge clk);
        reg_addr = ad;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        reg_wdata = ~d;
    endtask
    task rd(input logic [15:0] ad, output logic [15:0] d);
        @(negedge clk);
        reg_addr = ad;
        reg_read = 1'b1;
        @(negedge clk);
        reg_read = 1'b0;
        reg_addr = ~ad;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* t1l_link_status_autoneg_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "t1l_link_status_autoneg_regs_map.vh"
module t1l_link_status_autoneg_regs (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Register access from the management frame decoder
    input wire reg_write,
    input wire reg_read,
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    // Pin-level status inputs from the PHY core
    input wire remote_rx_ok_pin,
    input wire local_rx_ok_pin,
    input wire descrambler_ok_pin,
    input wire pma_link_ok_pin,
    // Autonegotiation engine status
    input wire restart_initiated,
    input wire page_stored,
    input wire [47:0] partner_base_ability_in,
    input wire negotiation_finished,
    input wire ability_valid,
    input wire negotiated_link_ok,
    input wire high_tx_amplitude_select,
    input wire negotiated_high_amplitude,
    // Control outputs
    output reg pcs_loopback_enable,
    output reg negotiation_enable,
    output reg negotiation_restart,
    output reg [47:0] partner_base_ability,
    output reg tx_amplitude_high
);
    reg [3:0] sync1;
    reg [3:0] live;
    reg page_received;
    reg negotiated_link_latched;
    reg negotiation_done;
    reg seen_page;
    wire [3:0] latched;
    wire link_read;
    wire status_read;
    wire ctrl_write;
    reg [15:0] next_rdata;

    assign link_read = reg_read && (reg_addr == `ADDR_PMA_LINK_STATUS);
    assign status_read = reg_read && (reg_addr == `ADDR_AUTONEG_STATUS);
    assign ctrl_write = reg_write && (reg_addr == `ADDR_AUTONEG_CONTROL);

    // Pin status comes from another clock, two stages before use
    always @(posedge clk) begin
        if (!resetn) begin
            sync1 <= 4'h0;
            live <= 4'h0;
        end else begin
            sync1 <= {remote_rx_ok_pin, local_rx_ok_pin,
                      descrambler_ok_pin, pma_link_ok_pin};
            live <= sync1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_ll
            latch_low_flag u_flag (
                .clk(clk),
                .resetn(resetn),
                .live(live[i]),
                .release_read(link_read),
                .latched(latched[i])
            );
        end
    endgenerate

    // Control registers; reserved write bits are simply dropped
    always @(posedge clk) begin
        if (!resetn) begin
            pcs_loopback_enable <= 1'b0;
            negotiation_enable <= 1'b1;
            negotiation_restart <= 1'b0;
        end else begin
            if (reg_write && reg_addr == `ADDR_PCS_CONTROL) begin
                pcs_loopback_enable <= reg_wdata[`BIT_PCS_LOOPBACK_ENABLE];
            end
            if (ctrl_write) begin
                negotiation_enable <= reg_wdata[`BIT_NEGOTIATION_ENABLE];
            end
            if (ctrl_write && reg_wdata[`BIT_NEGOTIATION_RESTART]) begin
                negotiation_restart <= 1'b1;
            end else if (restart_initiated) begin
                negotiation_restart <= 1'b0;
            end
        end
    end

    // Autonegotiation status
    always @(posedge clk) begin
        if (!resetn) begin
            page_received <= 1'b0;
            seen_page <= 1'b0;
            partner_base_ability <= 48'h0;
            negotiated_link_latched <= 1'b0;
            negotiation_done <= 1'b0;
        end else begin
            if (page_stored) begin
                page_received <= 1'b1;
            end else if (status_read) begin
                page_received <= 1'b0;
            end
            if (negotiation_restart || !negotiation_enable) begin
                seen_page <= 1'b0;
            end else if (page_stored && !seen_page) begin
                seen_page <= 1'b1;
                partner_base_ability <= partner_base_ability_in;
            end
            if (!negotiated_link_ok) begin
                negotiated_link_latched <= 1'b0;
            end else if (status_read) begin
                negotiated_link_latched <= 1'b1;
            end
            negotiation_done <= negotiation_enable && negotiation_finished
                && negotiated_link_ok && ability_valid;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            tx_amplitude_high <= 1'b0;
        end else if (negotiation_enable) begin
            tx_amplitude_high <= negotiated_high_amplitude;
        end else begin
            tx_amplitude_high <= high_tx_amplitude_select;
        end
    end

    always @* begin
        next_rdata = 16'h0000;
        case (reg_addr)
            `ADDR_PMA_LINK_STATUS: begin
                next_rdata[`BIT_REMOTE_RX_OK] = live[3];
                next_rdata[`BIT_REMOTE_RX_OK_LATCHED] = latched[3];
                next_rdata[`BIT_LOCAL_RX_OK] = live[2];
                next_rdata[`BIT_LOCAL_RX_OK_LATCHED] = latched[2];
                next_rdata[`BIT_DESCRAMBLER_OK] = live[1];
                next_rdata[`BIT_DESCRAMBLER_OK_LATCHED] = latched[1];
                next_rdata[`BIT_PMA_LINK_OK] = live[0];
                next_rdata[`BIT_PMA_LINK_OK_LATCHED] = latched[0];
            end
            `ADDR_PCS_CONTROL: begin
                next_rdata[`BIT_PCS_LOOPBACK_ENABLE] = pcs_loopback_enable;
            end
            `ADDR_AUTONEG_CONTROL: begin
                next_rdata[`BIT_NEGOTIATION_ENABLE] = negotiation_enable;
                next_rdata[`BIT_NEGOTIATION_RESTART] = negotiation_restart;
            end
            `ADDR_AUTONEG_STATUS: begin
                next_rdata[`BIT_PAGE_RECEIVED] = page_received;
                // Gate again: the registered flag lags a disable by a cycle
                next_rdata[`BIT_NEGOTIATION_DONE] = negotiation_done &&
                    negotiation_enable;
                next_rdata[`BIT_NEGOTIATION_CAPABLE] = 1'b1;
                next_rdata[`BIT_NEGOTIATED_LINK_LATCHED] =
                    negotiated_link_latched;
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    // Read data registered; value is sampled before the read side effect
    always @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

/* t1l_link_status_autoneg_regs_map.vh */
// Behaviour
// - Link status read releases its four latched-low pin flags; status read releases bit 2
// - Bit 12 remote rx ok, 13 latched
// - Bit 10 local rx ok, 11 latched
// - Bit 8 descrambler ok, 9 latched
// - Bit 0 link ok, 1 latched
// - Pcs control bit 14 enables loopback
// - Restart bit 9 self-clears once initiated
// - Page received latches high, read clears
// - Partner ability valid when page flag sets
// - Done bit 5, zero when disabled
// - Capable bit 3 always one; reset 0x0008
// - Negotiated link bit 2 latched low
// - Manual amplitude used only when autoneg off
`ifndef T1L_LINK_STATUS_AUTONEG_REGS_MAP_VH
`define T1L_LINK_STATUS_AUTONEG_REGS_MAP_VH
`define ADDR_PMA_LINK_STATUS 16'h8302
`define ADDR_PCS_CONTROL 16'h08e6
`define ADDR_AUTONEG_CONTROL 16'h0200
`define ADDR_AUTONEG_STATUS 16'h0201
`define RST_PMA_LINK_STATUS 16'h0000
`define RST_PCS_CONTROL 16'h0000
`define RST_AUTONEG_CONTROL 16'h1000
`define RST_AUTONEG_STATUS 16'h0008
`define BIT_REMOTE_RX_OK_LATCHED 13
`define BIT_REMOTE_RX_OK 12
`define BIT_LOCAL_RX_OK_LATCHED 11
`define BIT_LOCAL_RX_OK 10
`define BIT_DESCRAMBLER_OK_LATCHED 9
`define BIT_DESCRAMBLER_OK 8
`define BIT_PMA_LINK_OK_LATCHED 1
`define BIT_PMA_LINK_OK 0
`define BIT_PCS_LOOPBACK_ENABLE 14
`define BIT_NEGOTIATION_ENABLE 12
`define BIT_NEGOTIATION_RESTART 9
`define BIT_PAGE_RECEIVED 6
`define BIT_NEGOTIATION_DONE 5
`define BIT_NEGOTIATION_CAPABLE 3
`define BIT_NEGOTIATED_LINK_LATCHED 2
`endif

/* t1l_link_status_autoneg_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module t1l_link_status_autoneg_regs_tb;
    logic clk, resetn, w, r, ri, ps, fin, av, lok, hi, nhi, lb, en, rs, amp;
    logic [3:0] pin;
    logic [15:0] a, wd, rd, rv;
    logic [47:0] ab_in, pba;
    logic [15:0] lbit [4] = '{16'h0002, 16'h0200, 16'h0800, 16'h2000};
    int error_cnt = 0;
    int checks_done = 0;
    t1l_link_status_autoneg_regs DUT (.clk(clk), .resetn(resetn),
        .reg_write(w), .reg_read(r), .reg_addr(a), .reg_wdata(wd),
        .reg_rdata(rd), .remote_rx_ok_pin(pin[3]), .local_rx_ok_pin(pin[2]),
        .descrambler_ok_pin(pin[1]), .pma_link_ok_pin(pin[0]),
        .restart_initiated(ri), .page_stored(ps),
        .partner_base_ability_in(ab_in), .negotiation_finished(fin),
        .ability_valid(av), .negotiated_link_ok(lok),
        .high_tx_amplitude_select(hi), .negotiated_high_amplitude(nhi),
        .pcs_loopback_enable(lb), .negotiation_enable(en),
        .negotiation_restart(rs), .partner_base_ability(pba),
        .tx_amplitude_high(amp));
    mgmt_host_model host (.clk(clk), .reg_write(w), .reg_read(r),
        .reg_addr(a), .reg_wdata(wd), .reg_rdata(rd));
    task chk(input string n, input logic [47:0] e, input logic [47:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task rchk(input logic [15:0] ad, input logic [15:0] e);
        host.rd(ad, rv);
        chk("reg_rdata", e, rv);
    endtask
    task test_done;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Pins pass a two-stage synchroniser, so settle for four cycles
    task pins(input logic [3:0] v);
        pin = v;
        repeat (4) @(negedge clk);
    endtask
    task t_latch;
        pins(4'hf);
        rchk(16'h8302, 16'h1501);
        rchk(16'h8302, 16'h3f03);
        for (int i = 0; i < 4; i++) begin
            pins(4'hf ^ (4'h1 << i));
            rchk(16'h8302, 16'h3f03 ^ lbit[i] ^ (lbit[i] >> 1));
            pins(4'hf);
            rchk(16'h8302, 16'h3f03 ^ lbit[i]);
            rchk(16'h8302, 16'h3f03);
        end
    endtask
    task t_loop;
        host.wr(16'h08e6, 16'hffff);
        chk("pcs_loopback_enable", 1, lb);
        rchk(16'h08e6, 16'h4000);
        host.wr(16'h08e6, 16'h0000);
        chk("pcs_loopback_enable", 0, lb);
        rchk(16'h1234, 16'h0000);
        host.wr(16'h0201, 16'hffff);
        rchk(16'h0201, 16'h0008);
    endtask
    task t_an;
        host.wr(16'h0200, 16'hffff);
        chk("negotiation_restart", 1, rs);
        rchk(16'h0200, 16'h1200);
        rchk(16'h0200, 16'h1200);
        ri = 1'b1;
        @(negedge clk);
        ri = 1'b0;
        rchk(16'h0200, 16'h1000);
        host.wr(16'h0200, 16'h0000);
        chk("negotiation_enable", 0, en);
        {hi, nhi, fin, av, lok} = 5'b10111;
        repeat (3) @(negedge clk);
        chk("tx_amplitude_high", 1, amp);
        rchk(16'h0201, 16'h0008);
        host.wr(16'h0200, 16'h1000);
        repeat (3) @(negedge clk);
        chk("tx_amplitude_high", 0, amp);
        rchk(16'h0201, 16'h002c);
        lok = 1'b0;
        repeat (2) @(negedge clk);
        lok = 1'b1;
        repeat (3) @(negedge clk);
        rchk(16'h0201, 16'h0028);
        rchk(16'h0201, 16'h002c);
    endtask
    task t_page;
        ab_in = 48'h0123_4567_89ab;
        ps = 1'b1;
        @(negedge clk);
        ps = 1'b0;
        ab_in = 48'h0;
        repeat (2) @(negedge clk);
        chk("partner_base_ability", 48'h0123_4567_89ab, pba);
        rchk(16'h0201, 16'h006c);
        rchk(16'h0201, 16'h002c);
        ab_in = 48'hfedc_ba98_7654;
        ps = 1'b1;
        @(negedge clk);
        ps = 1'b0;
        chk("partner_base_ability", 48'h0123_4567_89ab, pba);
        rchk(16'h0201, 16'h006c);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #5000;
        error_cnt++;
        test_done;
    end
    initial begin
        {resetn, ri, ps, fin, av, lok, hi, nhi} = 8'h00;
        pin = 4'h0;
        ab_in = 48'h0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        rchk(16'h8302, 16'h0000);
        rchk(16'h08e6, 16'h0000);
        rchk(16'h0200, 16'h1000);
        rchk(16'h0201, 16'h0008);
        t_latch;
        t_loop;
        t_an;
        t_page;
        test_done;
    end
endmodule
bind t1l_link_status_autoneg_regs t1l_regs_asserts chk_i (.clk(clk),
    .resetn(resetn), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .restart_initiated(restart_initiated),
    .high_tx_amplitude_select(high_tx_amplitude_select),
    .pcs_loopback_enable(pcs_loopback_enable),
    .negotiation_enable(negotiation_enable),
    .negotiation_restart(negotiation_restart),
    .tx_amplitude_high(tx_amplitude_high));
`default_nettype wire

/* t1l_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module t1l_regs_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register access
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // Control
    input wire logic restart_initiated,
    input wire logic high_tx_amplitude_select,
    input wire logic pcs_loopback_enable,
    input wire logic negotiation_enable,
    input wire logic negotiation_restart,
    input wire logic tx_amplitude_high
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic ctl_wr;
    assign ctl_wr = reg_write && reg_addr == 16'h0200;
    rst_val_a: assert property ($rose(resetn) |->
        negotiation_enable && !pcs_loopback_enable) else $error("bad reset");
    loop_wr_a: assert property (reg_write && reg_addr == 16'h08e6 |=>
        pcs_loopback_enable == $past(reg_wdata[14])) else $error("loopback");
    negotiation_enable_a: assert property (ctl_wr |=>
        negotiation_enable == $past(reg_wdata[12])) else $error("enable");
    rs_req_a: assert property (ctl_wr && reg_wdata[9] |=>
        negotiation_restart) else $error("restart not set");
    rs_hold_a: assert property (negotiation_restart && !restart_initiated
        |=> negotiation_restart) else $error("restart lost");
    rs_clr_a: assert property (negotiation_restart && restart_initiated
        && !ctl_wr |=> !negotiation_restart) else $error("restart stuck");
    amp_man_a: assert property (!negotiation_enable && !ctl_wr |=>
        tx_amplitude_high == $past(high_tx_amplitude_select))
        else $error("manual amplitude");
    done_off_a: assert property (reg_read && reg_addr == 16'h0201
        && !negotiation_enable |=> !reg_rdata[5]) else $error("done while off");
    unmap_rd_a: assert property (reg_read && !(reg_addr inside
        {16'h8302, 16'h08e6, 16'h0200, 16'h0201}) |=> reg_rdata == 16'h0000)
        else $error("unmapped read");
    cover property (ctl_wr && reg_wdata[9]);
    cover property (negotiation_restart && restart_initiated);
    cover property (reg_read && reg_addr == 16'h8302);
endmodule
`default_nettype wire
